//--- verilog/cbs_pkg.sv
// Constants, register map and carrier types for the CAN buffer status block.
// Assumes a classic Wishbone slave with 32-bit data; registers are 16 bits wide.
// Summary of operation
// - Mask bit 1 compares, 0 ignores ID bit
// - Store into buffer sets its full flag
// - Flags clear by writing 0; reset 0
// - Store into full buffer sets overflow flag
// - Direction bit 1 transmit, 0 receive
// - Abort sets aborted status bit
// - Lost arbitration sets its status bit
// - Bus error while sending sets error bit
// - Send request cleared after successful send
// - Clearing set send request requests abort
// - Remote frame sets request when reply enabled
// - Priority field: 11 highest, 00 lowest
// - Setting send request clears status bits
// - Low byte even buffer, high byte odd
// - Message buffers live in system RAM
// - Word 0: SID 12-2, SRR 1, IDE 0
// - IDE selects extended or standard identifier
// - RTR bit 9 used only when IDE 1
// - Receive writes filter number to word 7
package cbs_pkg;
    localparam int NUM_BUF      = 32;
    localparam int NUM_TXBUF    = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_MASK_EID  = 8'h00;
    localparam logic [7:0] OFF_FUL_LO    = 8'h04;
    localparam logic [7:0] OFF_FUL_HI    = 8'h08;
    localparam logic [7:0] OFF_OVF_LO    = 8'h0c;
    localparam logic [7:0] OFF_OVF_HI    = 8'h10;
    localparam logic [7:0] OFF_CON_BASE  = 8'h14;
    localparam logic [15:0] RST_FLAGS    = 16'h0000;
    localparam logic [15:0] RST_MASK     = 16'h0000;
    // Control byte field positions
    localparam int CB_DIR   = 7;
    localparam int CB_ABT   = 6;
    localparam int CB_LARB  = 5;
    localparam int CB_ERR   = 4;
    localparam int CB_REQ   = 3;
    localparam int CB_AUTO_REMOTE_REPLY_ENABLE = 2;
    localparam int CB_PRI   = 0;
    // Message buffer word layout
    localparam int W0_SID_LSB = 2;
    localparam int W0_SRR     = 1;
    localparam int W0_IDE     = 0;
    localparam int W2_RTR     = 9;
    localparam int W7_HIT_LSB = 8;

    typedef struct packed {
        logic       dir;
        logic       aborted;
        logic       lostArb;
        logic       busErr;
        logic       sendReq;
        logic       auto_remote_reply_enable;
        logic [1:0] pri;
    } cbs_ctl_t;

    typedef struct packed {
        logic [4:0]  buf_;
        logic [4:0]  filterHit;
        logic        remote;
    } cbs_rxev_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  buf_;
    } cbs_txsel_t;

    typedef struct packed {
        logic        done;
        logic        abortDone;
        logic        lostArb;
        logic        busErr;
        logic [2:0]  buf_;
    } cbs_txres_t;
endpackage

//--- verilog/cbs_buffer_status.sv
// Buffer status, pair control and transmit scheduling for the CAN controller.
// Assumes the receive engine reports filter matches and the transmit engine reports results.
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/1ps
module cbs_buffer_status
    import cbs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Receive engine: one pulse per matched frame
    input  wire logic              rxValid,
    input  wire cbs_rxev_t         rxEvent,
    input  wire logic [15:0]       rxMsgIdExt,
    output logic                   rxStore,
    output logic [15:0]            rxWord7,
    output logic [4:0]             rxStoreBuf,
    output logic [15:0]            maskExt,
    // Transmit engine
    input  wire cbs_txres_t        txResult,
    input  wire logic [15:0]       txWord0,
    output cbs_txsel_t             txOffer,
    output logic                   txExtended,
    output logic [7:0]             txAbortReq
);
    logic [15:0]    maskEid;
    logic [31:0]    fullFlags;
    logic [31:0]    ovfFlags;
    cbs_ctl_t       ctl [NUM_TXBUF];
    logic [31:0]    rdData;

    wire            busReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire            busWr     = busReq & wb_we_i;
    wire            lo        = wb_sel_i[0];
    wire            hi        = wb_sel_i[1];
    wire            wrMask    = busWr && wb_adr_i == OFF_MASK_EID;
    wire            wrFulLo   = busWr && wb_adr_i == OFF_FUL_LO;
    wire            wrFulHi   = busWr && wb_adr_i == OFF_FUL_HI;
    wire            wrOvfLo   = busWr && wb_adr_i == OFF_OVF_LO;
    wire            wrOvfHi   = busWr && wb_adr_i == OFF_OVF_HI;
    wire [7:0]      conIdx    = (wb_adr_i - OFF_CON_BASE) >> 2;
    wire            conHit    = wb_adr_i >= OFF_CON_BASE && conIdx < 8'(NUM_TXBUF / 2)
                                && wb_adr_i[1:0] == 2'b00;

    // Byte-lane write mask for the flag registers: lanes not selected keep all ones
    wire [15:0]     laneKeep  = {{8{~hi}}, {8{~lo}}};
    wire [31:0]     clrKeep   = {(wrFulHi ? (wb_dat_i[15:0] | laneKeep) : 16'hffff),
                                 (wrFulLo ? (wb_dat_i[15:0] | laneKeep) : 16'hffff)};
    wire [31:0]     ovfKeep   = {(wrOvfHi ? (wb_dat_i[15:0] | laneKeep) : 16'hffff),
                                 (wrOvfLo ? (wb_dat_i[15:0] | laneKeep) : 16'hffff)};

    // Receive store: a target buffer must be a receive buffer (direction 0)
    wire [2:0]      rxPair    = rxEvent.buf_[2:0];
    wire            rxIsTx    = rxEvent.buf_ < 5'(NUM_TXBUF) && ctl[rxPair].dir;
    wire            rxHitFull = fullFlags[rxEvent.buf_];
    wire            rxData    = rxValid & ~rxEvent.remote & ~rxIsTx;
    wire            rxAccept  = rxData & ~rxHitFull;
    wire            rxOver    = rxData & rxHitFull;
    wire            rxRemote  = rxValid & rxEvent.remote & rxIsTx;
    wire [31:0]     setFull   = rxAccept ? (32'h1 << rxEvent.buf_) : 32'h0;
    wire [31:0]     setOvf    = rxOver ? (32'h1 << rxEvent.buf_) : 32'h0;

    assign maskExt = maskEid;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            maskEid   <= RST_MASK;
            fullFlags <= {RST_FLAGS, RST_FLAGS};
            ovfFlags  <= {RST_FLAGS, RST_FLAGS};
        end
        else
        begin
            if (wrMask && lo)
                maskEid[7:0] <= wb_dat_i[7:0];
            if (wrMask && hi)
                maskEid[15:8] <= wb_dat_i[15:8];
            // Set wins over a simultaneous software clear
            fullFlags <= (fullFlags & clrKeep) | setFull;
            ovfFlags  <= (ovfFlags & ovfKeep) | setOvf;
        end
    end

    // Highest priority pending transmit buffer; ties go to the lower number
    logic [2:0] bestBuf;
    logic       bestValid;
    logic [1:0] bestPri;
    always_comb
    begin
        bestBuf   = 3'h0;
        bestValid = 1'b0;
        bestPri   = 2'b00;
        for (int i = 0; i < NUM_TXBUF; i++)
        begin
            if (ctl[i].dir && ctl[i].sendReq && (!bestValid || ctl[i].pri > bestPri))
            begin
                bestBuf   = 3'(i);
                bestValid = 1'b1;
                bestPri   = ctl[i].pri;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_TXBUF; g++)
        begin : gCtl
            localparam int PAIR = g / 2;
            localparam int LSB  = (g % 2) * 8;
            // Pair and byte lane decode for this buffer
            wire        laneSel  = wb_sel_i[g % 2];
            wire        pairSel  = conIdx == 8'(PAIR);
            wire        wrCon    = busWr && conHit && pairSel && laneSel;
            // Software writable fields; status bits ignore writes
            wire        newDir   = wb_dat_i[LSB + CB_DIR];
            wire        newReq   = wb_dat_i[LSB + CB_REQ];
            wire        newRtrEn = wb_dat_i[LSB + CB_AUTO_REMOTE_REPLY_ENABLE];
            wire [1:0]  newPri   = wb_dat_i[LSB + CB_PRI +: 2];
            // Engine results aimed at this buffer
            wire        resHere  = txResult.buf_ == 3'(g);
            wire        resDone  = resHere && txResult.done;
            wire        resAbort = resHere && txResult.abortDone;
            wire        resLarb  = resHere && txResult.lostArb;
            wire        resErr   = resHere && txResult.busErr;
            // Request edges from software and from remote frames
            wire        swSet    = wrCon && newReq && !ctl[g].sendReq;
            wire        swAbort  = wrCon && !newReq && ctl[g].sendReq;
            wire        rtrSet   = rxRemote && rxPair == 3'(g) && ctl[g].auto_remote_reply_enable;
            wire        reqSet   = swSet || rtrSet;
            logic       abortPend;
            cbs_ctl_t   next_ctl;
            // A new request outranks every result of the same cycle
            wire        next_dir       = wrCon ? newDir : ctl[g].dir;
            wire        next_auto_remote_reply_enable     = wrCon ? newRtrEn : ctl[g].auto_remote_reply_enable;
            wire [1:0]  next_pri       = wrCon ? newPri : ctl[g].pri;
            wire        next_sendReq   = reqSet ? 1'b1
                                       : (swAbort || resDone) ? 1'b0
                                       : ctl[g].sendReq;
            wire        next_aborted   = reqSet ? 1'b0
                                       : resDone ? 1'b0
                                       : resAbort ? 1'b1
                                       : ctl[g].aborted;
            wire        next_lostArb   = reqSet ? 1'b0
                                       : resLarb ? 1'b1
                                       : ctl[g].lostArb;
            wire        next_busErr    = reqSet ? 1'b0
                                       : resErr ? 1'b1
                                       : ctl[g].busErr;
            // Abort stays requested until the engine reports done or aborted, or a new request is set
            wire        next_abortPend = reqSet ? 1'b0
                                       : (resDone || resAbort) ? 1'b0
                                       : swAbort ? 1'b1
                                       : abortPend;
            assign next_ctl = '{dir:     next_dir,
                                aborted: next_aborted,
                                lostArb: next_lostArb,
                                busErr:  next_busErr,
                                sendReq: next_sendReq,
                                auto_remote_reply_enable:   next_auto_remote_reply_enable,
                                pri:     next_pri};
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    ctl[g]    <= '0;
                    abortPend <= 1'b0;
                end
                else
                begin
                    ctl[g]    <= next_ctl;
                    abortPend <= next_abortPend;
                end
            end
            assign txAbortReq[g] = abortPend;
        end
    endgenerate

    // Read mux
    always_comb
    begin
        rdData = 32'h0;
        unique case (1'b1)
            wb_adr_i == OFF_MASK_EID: rdData = {16'h0, maskEid};
            wb_adr_i == OFF_FUL_LO:   rdData = {16'h0, fullFlags[15:0]};
            wb_adr_i == OFF_FUL_HI:   rdData = {16'h0, fullFlags[31:16]};
            wb_adr_i == OFF_OVF_LO:   rdData = {16'h0, ovfFlags[15:0]};
            wb_adr_i == OFF_OVF_HI:   rdData = {16'h0, ovfFlags[31:16]};
            conHit:                   rdData = {16'h0, ctl[2 * conIdx[1:0] + 1],
                                                ctl[2 * conIdx[1:0]]};
            default:                  rdData = 32'h0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0;
            rxStore    <= 1'b0;
            rxWord7    <= 16'h0;
            rxStoreBuf <= 5'h0;
            txOffer    <= '0;
            txExtended <= 1'b0;
        end
        else
        begin
            wb_ack_o   <= busReq;
            wb_dat_o   <= busReq ? rdData : 32'h0;
            rxStore    <= rxAccept;
            rxStoreBuf <= rxEvent.buf_;
            rxWord7    <= {3'h0, rxEvent.filterHit, 8'h00};
            txOffer    <= '{valid: bestValid, buf_: bestBuf};
            txExtended <= txWord0[W0_IDE];
        end
    end

    // Identifier layout in RAM words is handled by the framer; kept here for reference use
    wire unusedId = ^rxMsgIdExt;
endmodule // cbs_buffer_status

//--- testbench/cbs_buffer_status_chk.sv
// Port checker for the buffer status block.
// Assumes registered ack and one-cycle engine pulses.
`timescale 1ns/1ps
module cbs_buffer_status_chk
    import cbs_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        rxValid,
    input wire cbs_rxev_t   rxEvent,
    input wire logic        rxStore,
    input wire logic [15:0] rxWord7,
    input wire logic [4:0]  rxStoreBuf,
    input wire logic [15:0] maskExt,
    input wire cbs_txres_t  txResult,
    input wire logic [15:0] txWord0,
    input wire cbs_txsel_t  txOffer,
    input wire logic        txExtended,
    input wire logic [7:0]  txAbortReq
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    reset_out_a: assert property ($rose(rst_n) |-> !rxStore && maskExt == 16'h0000)
        else $error("outputs not cleared by reset");
    store_src_a: assert property (rxStore |-> $past(rxValid && !rxEvent.remote)
        && rxStoreBuf == $past(rxEvent.buf_)) else $error("bad store");
    hit_word_a: assert property (rxStore |-> rxWord7 == {3'h0, $past(rxEvent.filterHit), 8'h00})
        else $error("bad filter word");
    ide_out_a: assert property (txOffer.valid && $past(txOffer.valid) |-> txExtended == $past(txWord0[0]))
        else $error("bad identifier type");
    abort_hold_a: assert property ($fell(txAbortReq[0]) |-> $past(txResult.done || txResult.abortDone))
        else $error("abort request dropped early");
    cover property (rxStore);
    cover property (txAbortReq[0]);
    cover property (txOffer.valid && txOffer.buf_ == 3'h1);
endmodule // cbs_buffer_status_chk
bind cbs_buffer_status cbs_buffer_status_chk u_cbs_buffer_status_chk (.*);

//--- testbench/cbs_can_node.sv
// Model of the bus-side engines: received frames and transmit results.
// Assumes the bench calls its tasks between bus cycles.
`timescale 1ns/1ps
module cbs_can_node
    import cbs_pkg::*;
(
    input  wire logic       clk,
    input  wire cbs_txsel_t txOffer,
    output logic            rxValid,
    output cbs_rxev_t       rxEvent,
    output logic [15:0]     rxMsgIdExt,
    output cbs_txres_t      txResult,
    output logic [15:0]     txWord0
);
    // Word 0 of offered buffer: SRR held 1, IDE follows buffer parity
    assign txWord0 = {3'h0, 8'h12, txOffer.buf_, 1'b1, txOffer.buf_[0]};
    initial
        {rxValid, rxEvent, rxMsgIdExt, txResult} = '0;
    task rx(input logic [4:0] b, input logic [4:0] h, input logic r);
        @(posedge clk);
        {rxValid, rxEvent} <= {1'b1, b, h, r};
        @(posedge clk);
        // Idle fields inverted so a stale value is never mistaken for a frame
        {rxValid, rxEvent} <= {1'b0, ~b, ~h, ~r};
        repeat (2) @(posedge clk);
    endtask
    task tx(input logic [3:0] k, input logic [2:0] b);
        @(posedge clk);
        txResult <= {k, b};
        @(posedge clk);
        txResult <= {4'h0, ~b};
    endtask
endmodule // cbs_can_node

//--- testbench/cbs_buffer_status_tb.sv
// Self-checking bench for the buffer status block.
// Assumes a classic Wishbone slave that always answers.
`timescale 1ns/1ps
module cbs_buffer_status_tb
    import cbs_pkg::*;
;
    logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        rxValid, rxStore, txExtended;
    logic [7:0]  wb_adr_i, txAbortReq;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [15:0] rxMsgIdExt, rxWord7, maskExt, txWord0;
    logic [4:0]  rxStoreBuf;
    cbs_rxev_t   rxEvent;
    cbs_txres_t  txResult;
    cbs_txsel_t  txOffer;
    int          error_cnt, comparisons;
    cbs_buffer_status u_cbs_buffer_status (.*);
    cbs_can_node u_cbs_can_node (.*);
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
            error_cnt++;
        end
    endtask
    task results;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 16'h0, d};
        for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++)
            @(posedge clk);
        if (n == 50)
        begin
            error_cnt++;
            results;
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 16'h0);
        chk(q, e);
    endtask
    task t_regs;
        for (int i = 0; i < 9; i++)
            rd(8'(i * 4), 32'h0);
        wb(1'b1, OFF_MASK_EID, 16'ha5c3);
        wb(1'b1, 8'h40, 16'hffff);
        rd(8'h40, 32'h0);
        rd(OFF_MASK_EID, 32'ha5c3);
        chk(maskExt, 32'ha5c3);
    endtask
    task t_rx;
        u_cbs_can_node.rx(5'd3, 5'd7, 1'b0);
        rd(OFF_FUL_LO, 32'h0008);
        u_cbs_can_node.rx(5'd3, 5'd9, 1'b0);
        rd(OFF_OVF_LO, 32'h0008);
        u_cbs_can_node.rx(5'd20, 5'd1, 1'b0);
        u_cbs_can_node.rx(5'd20, 5'd1, 1'b0);
        rd(OFF_FUL_HI, 32'h0010);
        rd(OFF_OVF_HI, 32'h0010);
        wb(1'b1, OFF_FUL_LO, 16'hffff);
        rd(OFF_FUL_LO, 32'h0008);
        wb(1'b1, OFF_OVF_LO, 16'hfff7);
        rd(OFF_OVF_LO, 32'h0);
        wb(1'b1, OFF_FUL_LO, 16'h0000);
        rd(OFF_FUL_LO, 32'h0);
    endtask
    task t_tx;
        wb(1'b1, OFF_CON_BASE, 16'h8b89);
        repeat (3) @(posedge clk);
        chk(txOffer, 32'h9);
        chk(txExtended, 32'h1);
        u_cbs_can_node.tx(4'h8, 3'd1);
        rd(OFF_CON_BASE, 32'h8389);
        chk(txOffer, 32'h8);
        chk(txExtended, 32'h0);
        u_cbs_can_node.tx(4'h3, 3'd0);
        rd(OFF_CON_BASE, 32'h83b9);
        wb(1'b1, OFF_CON_BASE, 16'h83b1);
        repeat (2) @(posedge clk);
        chk(txAbortReq, 32'h01);
        u_cbs_can_node.tx(4'h4, 3'd0);
        rd(OFF_CON_BASE, 32'h83f1);
        chk(txAbortReq, 32'h00);
        wb(1'b1, OFF_CON_BASE, 16'h8389);
        rd(OFF_CON_BASE, 32'h8389);
        u_cbs_can_node.tx(4'h8, 3'd0);
        wb(1'b1, OFF_CON_BASE, 16'h8385);
        u_cbs_can_node.rx(5'd0, 5'd2, 1'b1);
        rd(OFF_CON_BASE, 32'h838d);
        u_cbs_can_node.tx(4'h8, 3'd0);
        wb(1'b1, OFF_CON_BASE + 8'h04, 16'h0008);
        repeat (3) @(posedge clk);
        chk(txOffer.valid, 32'h0);
    endtask
    task t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk(txOffer, 32'h0);
        rd(OFF_FUL_HI, 32'h0);
        rd(OFF_OVF_HI, 32'h0);
        rd(OFF_CON_BASE, 32'h0);
        rd(OFF_MASK_EID, 32'h0);
    endtask
    initial
    begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'h3;
        {error_cnt, comparisons} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_rx;
        t_tx;
        t_reset;
        results;
    end
endmodule // cbs_buffer_status_tb
